/* hdl/gpw_consts.svh */
// constants for the grouped pwm block: offsets, fields, resets, timing
`ifndef GPW_CONSTS_SVH
`define GPW_CONSTS_SVH
`define GPW_ADDR_CMD 5'h00
`define GPW_ADDR_RATE 5'h04
`define GPW_ADDR_DUTY 5'h08
`define GPW_ADDR_STATUS 5'h0C
`define GPW_ADDR_QUERY 5'h10
`define GPW_ADDR_RESP 5'h14
`define GPW_ADDR_PINS 5'h18
`define GPW_ADDR_DISLVL 5'h1C
`define GPW_CMD_LINE_LSB 0
`define GPW_CMD_OP_LSB 4
`define GPW_NLINES 7
`define GPW_NGRP 3
`define GPW_NIO 5
`define GPW_DUTY_W 20
`define GPW_RATE_W 15
`define GPW_DIV_W 27
`define GPW_RATE_MIN 15'h0064
`define GPW_RATE_MAX 15'h7530
`define GPW_TB_HZ 27'h44AA200
`define GPW_TB_MHZ 7'h48
`define GPW_MCLK_MHZ 7'h28
`define GPW_STEP_BASE (`GPW_TB_MHZ / `GPW_MCLK_MHZ)
`define GPW_STEP_FRAC (`GPW_TB_MHZ % `GPW_MCLK_MHZ)
`define GPW_DIV_LAST 5'h1A
`define GPW_GRP0_MASK 7'h07
`define GPW_GRP1_MASK 7'h38
`define GPW_GRP2_MASK 7'h40
`define GPW_CR 8'h0D
`define GPW_BOARD_PREFIX 8'h70
`define GPW_BOARD_ADDR 8'h30
`define GPW_DISLVL_RST 2'h0
`endif

/* hdl/gpw_pkg.sv */
// types shared by the grouped pwm block
`default_nettype none
`include "gpw_consts.svh"
package gpw_pkg;
   typedef logic [`GPW_DUTY_W-1:0] gpw_duty_t;
   typedef logic [`GPW_RATE_W-1:0] gpw_rate_t;
   typedef enum logic [1:0] {OP_CONVERT, OP_REVERT, OP_DUTY, OP_QUERY} gpw_op_e;
   typedef enum logic {DIV_IDLE, DIV_RUN} gpw_div_e;
endpackage
`default_nettype wire

/* hdl/gpw_grp_if.sv */
// link between the command logic and one channel group counter
`timescale 1ns/1ps
`default_nettype none
interface gpw_grp_if;
   import gpw_pkg::*;
   logic start;
   gpw_rate_t rate;
   logic busy;
   logic ready;
   gpw_duty_t period;
   gpw_duty_t count;
   modport ctl(output start, output rate, input busy, input ready, input period, input count);
   modport grp(input start, input rate, output busy, output ready, output period, output count);
endinterface
`default_nettype wire

/* hdl/gpw_group_counter.sv */
// one channel group: period divider and timebase counter
`timescale 1ns/1ps
`default_nettype none
`include "gpw_consts.svh"
module gpw_group_counter
   import gpw_pkg::*;
(
   // clock and control
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   // group link
   gpw_grp_if.grp grp
);
   gpw_div_e divState;
   logic [`GPW_DIV_W-1:0] rem;
   logic [`GPW_DIV_W-1:0] dvd;
   logic [`GPW_DIV_W-1:0] quo;
   logic [4:0] bitCnt;
   logic [6:0] frac;
   logic [`GPW_DIV_W-1:0] remShift;
   logic remGe;
   logic [6:0] next_frac;
   logic [1:0] step;
   logic [`GPW_DUTY_W:0] cntSum;
   gpw_duty_t next_count;

   assign grp.busy = (divState == DIV_RUN);

   // restoring division of the timebase by the rate
   always_comb begin
      remShift = {rem[`GPW_DIV_W-2:0], dvd[`GPW_DIV_W-1]};
      remGe = remShift >= {12'h000, grp.rate};
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         divState <= DIV_IDLE;
         rem <= '0;
         dvd <= '0;
         quo <= '0;
         bitCnt <= 5'h00;
         grp.period <= '0;
         grp.ready <= 1'b0;
      end else if (ce) begin
         unique case (divState)
            DIV_IDLE: begin
               if (grp.start) begin
                  dvd <= `GPW_TB_HZ;
                  rem <= '0;
                  quo <= '0;
                  bitCnt <= `GPW_DIV_LAST;
                  grp.ready <= 1'b0;
                  divState <= DIV_RUN;
               end
            end
            DIV_RUN: begin
               rem <= remGe ? remShift - {12'h000, grp.rate} : remShift;
               dvd <= {dvd[`GPW_DIV_W-2:0], 1'b0};
               quo <= {quo[`GPW_DIV_W-2:0], remGe};
               if (bitCnt == 5'h00) begin
                  grp.period <= {quo[`GPW_DUTY_W-2:0], remGe};
                  grp.ready <= 1'b1;
                  divState <= DIV_IDLE;
               end else begin
                  bitCnt <= bitCnt - 5'h01;
               end
            end
         endcase
      end
   end

   // 72 MHz ticks spread over 40 MHz cycles
   always_comb begin
      next_frac = frac + 7'(`GPW_STEP_FRAC);
      step = 2'(`GPW_STEP_BASE);
      if (next_frac >= `GPW_MCLK_MHZ) begin
         next_frac = next_frac - `GPW_MCLK_MHZ;
         step = step + 2'h1;
      end
      cntSum = {1'b0, grp.count} + {19'h00000, step};
      if (cntSum >= {1'b0, grp.period}) begin
         cntSum = cntSum - {1'b0, grp.period};
      end
      next_count = cntSum[`GPW_DUTY_W-1:0];
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         grp.count <= '0;
         frac <= 7'h00;
      end else if (ce) begin
         if (!grp.ready) begin
            grp.count <= '0;
            frac <= 7'h00;
         end else begin
            grp.count <= next_count;
            frac <= next_frac;
         end
      end
   end
endmodule
`default_nettype wire

/* hdl/gpw_pwm_top.sv */
// grouped pwm output control: command registers, groups and pin drive
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "gpw_consts.svh"
module gpw_pwm_top
   import gpw_pkg::*;
(
   // clock and control
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // open-collector outputs
   output logic [1:0] ocDrive,
   // user and spare lines
   input wire logic [`GPW_NIO-1:0] ioIn,
   output logic [`GPW_NIO-1:0] ioOut,
   output logic [`GPW_NIO-1:0] ioOe_n
);
   gpw_rate_t rateArg;
   gpw_duty_t dutyArg;
   logic [1:0] disLvl;
   logic [`GPW_NLINES-1:0] lineEn;
   gpw_duty_t duty [`GPW_NLINES];
   logic [`GPW_NGRP-1:0] grpLock;
   logic [`GPW_NGRP-1:0] startPulse;
   gpw_rate_t grpRate [`GPW_NGRP];
   gpw_rate_t queryRate;
   logic queryValid;
   logic [`GPW_NGRP-1:0] grpBusy;
   logic [`GPW_NGRP-1:0] grpReady;
   gpw_duty_t grpPeriod [`GPW_NGRP];
   gpw_duty_t grpCount [`GPW_NGRP];
   logic [`GPW_NLINES-1:0] act;
   logic [31:0] rdMux;
   logic stall;
   logic wrTake;
   logic cmdTake;
   logic [2:0] cmdLine;
   gpw_op_e cmdOp;
   logic lineValid;
   logic [1:0] cmdGrp;
   logic [`GPW_NGRP-1:0] cmdGrpHot;
   logic [`GPW_NLINES-1:0] cmdLineHot;
   logic rateOk;
   logic dutyFits;
   logic lastInGrp;
   gpw_rate_t cmdGrpRate;
   logic convTake;
   logic dutyTake;
   logic revTake;
   logic queryTake;

   function automatic logic [1:0] grpOf(input logic [2:0] line);
      if (line < 3'h3) begin
         return 2'h0;
      end else if (line < 3'h6) begin
         return 2'h1;
      end
      return 2'h2;
   endfunction

   function automatic logic [`GPW_NLINES-1:0] grpMask(input logic [1:0] g);
      unique case (g)
         2'h0: return `GPW_GRP0_MASK;
         2'h1: return `GPW_GRP1_MASK;
         default: return `GPW_GRP2_MASK;
      endcase
   endfunction

   function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return res;
   endfunction

   // group counters
   gpw_grp_if grpBus [`GPW_NGRP] ();
   for (genvar g = 0; g < `GPW_NGRP; g++) begin : grp_gen
      assign grpBus[g].start = startPulse[g];
      assign grpBus[g].rate = grpRate[g];
      assign grpBusy[g] = grpBus[g].busy;
      assign grpReady[g] = grpBus[g].ready;
      assign grpPeriod[g] = grpBus[g].period;
      assign grpCount[g] = grpBus[g].count;
      gpw_group_counter u_cnt (
         .mclk(mclk),
         .reset(reset),
         .ce(ce),
         .grp(grpBus[g])
      );
   end

   // command decode
   always_comb begin
      stall = avs_write && (avs_address == `GPW_ADDR_CMD) && (|grpBusy || |startPulse);
      wrTake = avs_write && !avs_waitrequest;
      cmdTake = wrTake && (avs_address == `GPW_ADDR_CMD) && avs_byteenable[0];
      cmdLine = avs_writedata[`GPW_CMD_LINE_LSB +: 3];
      cmdOp = gpw_op_e'(avs_writedata[`GPW_CMD_OP_LSB +: 2]);
      lineValid = cmdLine < 3'(`GPW_NLINES);
      cmdGrp = grpOf(cmdLine);
      cmdGrpHot = 3'h1 << cmdGrp;
      cmdLineHot = 7'h01 << cmdLine;
      rateOk = (rateArg >= `GPW_RATE_MIN) && (rateArg <= `GPW_RATE_MAX);
      dutyFits = dutyArg < grpPeriod[cmdGrp];
      lastInGrp = ((lineEn & grpMask(cmdGrp)) & ~cmdLineHot) == 7'h00;
      cmdGrpRate = grpRate[cmdGrp];
      convTake = cmdTake && lineValid && (cmdOp == OP_CONVERT);
      dutyTake = cmdTake && lineValid && (cmdOp == OP_DUTY);
      revTake = cmdTake && lineValid && (cmdOp == OP_REVERT);
      queryTake = cmdTake && lineValid && (cmdOp == OP_QUERY);
   end

   // line state, group locks and rates
   always_ff @(posedge mclk) begin
      if (reset) begin
         lineEn <= 7'h00;
         grpLock <= 3'h0;
         startPulse <= 3'h0;
         queryRate <= '0;
         queryValid <= 1'b0;
         for (int i = 0; i < `GPW_NLINES; i++) begin
            duty[i] <= '0;
         end
         for (int g = 0; g < `GPW_NGRP; g++) begin
            grpRate[g] <= '0;
         end
      end else if (ce) begin
         startPulse <= 3'h0;
         if (convTake) begin
            if (grpLock[cmdGrp]) begin
               if (dutyFits) begin
                  lineEn[cmdLine] <= 1'b1; // rate ignored while locked
                  duty[cmdLine] <= dutyArg;
               end
            end else if (rateOk) begin
               grpLock[cmdGrp] <= 1'b1;
               grpRate[cmdGrp] <= rateArg;
               startPulse[cmdGrp] <= 1'b1;
               lineEn[cmdLine] <= 1'b1;
               duty[cmdLine] <= dutyArg;
            end
         end
         if (dutyTake && lineEn[cmdLine] && dutyFits) begin
            duty[cmdLine] <= dutyArg;
         end
         if (revTake) begin
            lineEn[cmdLine] <= 1'b0;
            if (lastInGrp) begin
               grpLock[cmdGrp] <= 1'b0;
            end
         end
         if (queryTake) begin
            queryRate <= cmdGrpRate;
            queryValid <= 1'b1;
         end
      end
   end

   // argument and level registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         rateArg <= '0;
         dutyArg <= '0;
         disLvl <= `GPW_DISLVL_RST;
      end else if (ce && wrTake) begin
         unique case (avs_address)
            `GPW_ADDR_RATE: begin
               rateArg <= 15'(merge32({17'h0, rateArg}, avs_writedata, avs_byteenable));
            end
            `GPW_ADDR_DUTY: begin
               dutyArg <= 20'(merge32({12'h0, dutyArg}, avs_writedata, avs_byteenable));
            end
            `GPW_ADDR_DISLVL: begin
               disLvl <= 2'(merge32({30'h0, disLvl}, avs_writedata, avs_byteenable));
            end
            default: begin
            end
         endcase
      end
   end

   // pwm compare per line
   always_comb begin
      for (int i = 0; i < `GPW_NLINES; i++) begin
         act[i] = lineEn[i] && grpReady[grpOf(3'(i))]
                  && (grpCount[grpOf(3'(i))] < duty[i]);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         ocDrive <= `GPW_DISLVL_RST;
         ioOut <= 5'h00;
         ioOe_n <= 5'h1F;
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            ocDrive[i] <= lineEn[i] ? act[i] : disLvl[i];
         end
         ioOut <= act[6:2];
         ioOe_n <= ~lineEn[6:2];
      end
   end

   // read mux
   always_comb begin
      unique case (avs_address)
         `GPW_ADDR_RATE: rdMux = {17'h0, rateArg};
         `GPW_ADDR_DUTY: rdMux = {12'h0, dutyArg};
         `GPW_ADDR_STATUS: rdMux = {17'h0, grpBusy, 1'b0, grpLock, 1'b0, lineEn};
         `GPW_ADDR_QUERY: rdMux = {15'h0, queryValid, 1'b0, queryRate};
         `GPW_ADDR_RESP: rdMux = {8'h0, `GPW_BOARD_PREFIX, `GPW_BOARD_ADDR, `GPW_CR};
         `GPW_ADDR_PINS: rdMux = {11'h0, ioIn, 3'h0, ioOe_n, 1'b0, ioOut, ocDrive};
         `GPW_ADDR_DISLVL: rdMux = {30'h0, disLvl};
         default: rdMux = 32'h00000000;
      endcase
   end

   // bus handshake: one wait cycle, longer for command writes while a divider runs or starts
   always_ff @(posedge mclk) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else if (ce) begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest && !stall);
         if (avs_read && avs_waitrequest) begin
            avs_readdata <= rdMux;
         end
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (reset);

   sequence s_req_ok;
      (avs_read || avs_write) && avs_waitrequest && !stall && ce;
   endsequence
   sequence s_ack;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   a_bus_answer: assert property (s_req_ok ##1 ce |-> s_ack)
      else $error("bus answer not one cycle wide");
   a_rate_lock: assert property ((convTake && ce && grpLock[cmdGrp]) |=>
      $stable(grpRate[0]) && $stable(grpRate[1]) && $stable(grpRate[2]))
      else $error("locked group rate changed");
   a_lock_has_line: assert property ((!grpLock[0] || (lineEn[2:0] != 3'h0)) &&
      (!grpLock[1] || (lineEn[5:3] != 3'h0)) && (!grpLock[2] || lineEn[6]))
      else $error("group locked with no pwm line");
   a_unlock_revert: assert property ((revTake && ce && lastInGrp) |=>
      (grpLock & $past(cmdGrpHot)) == 3'h0)
      else $error("group lock kept after last revert");
   a_oc_disabled: assert property ((ce && !lineEn[0]) |=> ocDrive[0] == $past(disLvl[0]))
      else $error("idle open-collector line not at disabled level");
   a_io_input: assert property ((ce && lineEn[6:2] == 5'h00) |=> ioOe_n == 5'h1F)
      else $error("idle bidirectional line driving");
   a_duty_take: assert property ((dutyTake && ce && lineEn[cmdLine] && dutyFits) |=>
      duty[$past(cmdLine)] == $past(dutyArg))
      else $error("duty change not taken");
   a_query_rate: assert property ((queryTake && ce) |=>
      queryValid && queryRate == $past(cmdGrpRate))
      else $error("query reported wrong rate");
   a_resp_term: assert property ((s_req_ok and avs_read && avs_address == `GPW_ADDR_RESP)
      |=> avs_readdata[7:0] == `GPW_CR)
      else $error("response not terminated by carriage return");
   a_pwm_wrap: assert property (grpReady[0] |-> grpCount[0] < grpPeriod[0])
      else $error("group counter passed its period");
   a_conv_group: assert property ((convTake && ce && cmdLine == 3'h6 && !grpLock[2]
      && rateOk) |=> grpLock[2] && lineEn[6] ##1 !grpReady[2])
      else $error("spare 3 not placed in group two");
endmodule
`default_nettype wire

/* test/gpw_host_model.sv */
// host side model: avalon-mm master issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module gpw_host_model (
   // clock
   input wire logic mclk,
   // avalon-mm master
   output logic [4:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   initial begin
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
   end

   // one access, held until waitrequest is seen low or 200 cycles have passed
   task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic ok);
      ok = 1'b0;
      rd = 32'h0;
      @(posedge mclk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      for (int n = 0; n < 200 && !ok; n++) begin
         @(posedge mclk);
         if (avs_waitrequest === 1'b0) begin
            ok = 1'b1;
            rd = avs_readdata;
         end
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // released lines do not keep the old value
      avs_address <= ~a;
      avs_writedata <= ~d;
   endtask
endmodule
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the grouped pwm block
`timescale 1ns/1ps
`default_nettype none
`include "gpw_consts.svh"
module tb_top;
   logic mclk;
   logic reset = 1'b1;
   logic ce = 1'b1;
   logic [4:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] ocDrive;
   logic [4:0] ioIn = 5'h00;
   logic [4:0] ioOut;
   logic [4:0] ioOe_n;
   logic [31:0] seed = 32'hDA8DA794;
   logic [31:0] q;
   int miscompares = 0;
   int cmp_count = 0;
   int rt[3] = '{0, 0, 0};
   int pr[3] = '{1, 1, 1};
   int lk[3] = '{0, 0, 0};
   int on[7] = '{0, 0, 0, 0, 0, 0, 0};
   int qr = 0;
   int r, d, l, op;

   gpw_pwm_top gpw_pwm_top_i (.mclk(mclk), .reset(reset), .ce(ce),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .ocDrive(ocDrive), .ioIn(ioIn), .ioOut(ioOut), .ioOe_n(ioOe_n));

   gpw_host_model gpw_host_model_i (.mclk(mclk), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic int grp(int ln);
      return ln < 3 ? 0 : (ln < 6 ? 1 : 2);
   endfunction

   function automatic logic pin(int ln);
      return ln < 2 ? ocDrive[ln] : ioOut[ln-2];
   endfunction

   task close_out();
      $display("compares %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task bus(input logic w, input logic [4:0] a, input logic [31:0] dd);
      logic ok;
      gpw_host_model_i.xfer(w, a, dd, q, ok);
      if (ok !== 1'b1) begin
         miscompares++;
         close_out();
      end
   endtask

   // command with arguments, then model update and status/query compare
   task cmd(input int o, input int ln, input int rr, input int dd);
      int gi;
      int s;
      bus(1'b1, `GPW_ADDR_RATE, 32'(rr));
      bus(1'b1, `GPW_ADDR_DUTY, 32'(dd));
      bus(1'b1, `GPW_ADDR_CMD, 32'((o << 4) | ln));
      gi = grp(ln);
      if (ln < 7) begin
         if (o == 0 && lk[gi] == 0 && rr >= 100 && rr <= 30000) begin
            lk[gi] = 1;
            rt[gi] = rr;
            pr[gi] = 72000000 / rr;
            on[ln] = 1;
         end else if (o == 0 && lk[gi] == 1 && dd < pr[gi]) begin
            on[ln] = 1;
         end
         if (o == 1) begin
            on[ln] = 0;
            s = 0;
            for (int i = 0; i < 7; i++) if (grp(i) == gi) s += on[i];
            if (s == 0) lk[gi] = 0;
         end
         if (o == 3) qr = 32'h10000 | rt[gi];
      end
      s = 0;
      for (int i = 0; i < 7; i++) s |= on[i] << i;
      for (int i = 0; i < 3; i++) s |= lk[i] << (8 + i);
      bus(1'b0, `GPW_ADDR_STATUS, 32'h0);
      check(q & 32'h7FF, 32'(s));
      bus(1'b0, `GPW_ADDR_QUERY, 32'h0);
      check(q, 32'(qr));
   endtask

   // high cycles over one window; counter steps 72/40 per mclk
   task meas(input int ln, input int win, input int expv);
      int n;
      n = 0;
      repeat (40) @(posedge mclk);
      repeat (win) begin
         @(posedge mclk);
         n += (pin(ln) === 1'b1) ? 1 : 0;
      end
      check(32'((n > expv - 4 && n < expv + 4) ? expv : n), 32'(expv));
   endtask

   initial begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      q = xs();
      ioIn <= q[4:0];
      bus(1'b0, `GPW_ADDR_RESP, 32'h0);
      check(q, 32'h0070300D);
      bus(1'b0, `GPW_ADDR_PINS, 32'h0);
      check(q, {11'h000, ioIn, 16'h1F00});
      bus(1'b1, `GPW_ADDR_DISLVL, 32'h3);
      $display("test reset done");
      cmd(0, 0, 20000, 1800);
      cmd(0, 1, 100, 900);
      cmd(0, 2, 20000, 3600);
      cmd(3, 1, 0, 0);
      cmd(0, 7, 20000, 10);
      meas(0, 2000, 1000);
      meas(1, 2000, 500);
      cmd(2, 1, 0, 2700);
      meas(0, 2000, 1000);
      meas(1, 2000, 1500);
      cmd(2, 1, 0, 3600);
      cmd(2, 5, 0, 100);
      meas(1, 2000, 1500);
      $display("test duty done");
      cmd(1, 0, 0, 0);
      check(32'(ocDrive[0]), 32'h1);
      cmd(1, 1, 0, 0);
      check(32'(ocDrive), 32'h3);
      cmd(0, 2, 10000, 3000);
      cmd(3, 0, 0, 0);
      check(32'(ioOe_n), 32'h1E);
      meas(2, 4000, 1666);
      @(posedge mclk);
      ce <= 1'b0;
      @(posedge mclk);
      q = 32'({ocDrive, ioOut, ioOe_n});
      d = 0;
      repeat (2500) begin
         @(posedge mclk);
         d += (32'({ocDrive, ioOut, ioOe_n}) !== q) ? 1 : 0;
      end
      check(32'(d), 32'h0);
      ce <= 1'b1;
      cmd(1, 2, 0, 0);
      check(32'(ioOe_n), 32'h1F);
      cmd(0, 6, 99, 10);
      cmd(0, 6, 30000, 1200);
      check(32'(ioOe_n), 32'h0F);
      $display("test revert done");
      repeat (14) begin
         q = xs();
         l = q % 7;
         op = (q >> 8) % 4;
         q = xs();
         r = 100 + q % 29901;
         q = xs();
         d = q % (lk[grp(l)] == 1 ? pr[grp(l)] : 72000000 / r);
         if (op == 2 && on[l] == 0) op = 0;
         cmd(op, l, r, d);
      end
      $display("test random done");
      close_out();
   end
endmodule
`default_nettype wire
